// file: spb_pkg.sv
// package: register map, field layout and shared types of the spi pin/baud block
package spb_pkg;
    // ********************************************************************
    // register map (word addresses on avalon, byte address = 4 * index)
    // ********************************************************************
    localparam logic [1:0] SPB_ADDR_FEATURE = 2'h0;
    localparam logic [1:0] SPB_ADDR_RATE = 2'h1;
    localparam logic [1:0] SPB_ADDR_MODE = 2'h2;

    // feature control field positions
    localparam int SPB_FC_MODF_EN = 4;
    localparam int SPB_FC_BIDIR_OE = 3;
    localparam int SPB_FC_STOP_WAIT = 1;
    localparam int SPB_FC_SINGLE = 0;
    localparam logic [7:0] SPB_FC_MASK = 8'h1b;
    localparam logic [7:0] SPB_FC_RESET = 8'h00;

    // bit rate select field positions
    localparam int SPB_BR_PRE_LSB = 4;
    localparam int SPB_BR_DIV_LSB = 0;
    localparam logic [7:0] SPB_BR_MASK = 8'h77;
    localparam logic [7:0] SPB_BR_RESET = 8'h00;

    // mode register: bit 0 master_select, bit 1 select_output_enable
    localparam int SPB_MD_MASTER = 0;
    localparam int SPB_MD_SELECT_OUTPUT_ENABLE = 1;
    localparam logic [7:0] SPB_MD_MASK = 8'h03;
    localparam logic [7:0] SPB_MD_RESET = 8'h00;

    // pin role of the slave-select pin
    typedef enum logic [1:0] {
        SPB_SS_SLAVE_IN = 2'b00,
        SPB_SS_GPIO = 2'b01,
        SPB_SS_FAULT_IN = 2'b10,
        SPB_SS_DRIVE_OUT = 2'b11
    } spb_ss_role_t;

    // pin routing decisions handed to the shifter and port logic
    typedef struct packed {
        spb_ss_role_t ss_role;
        logic miso_gpio;
        logic shared_on_mosi;
        logic shared_on_miso;
        logic shared_drive;
    } spb_route_t;
endpackage : spb_pkg

// file: spb_rate_gen.sv
// rate generator: prescaler feeding power-of-two divider
`timescale 1ns/10ps
module spb_rate_gen (
    input wire logic mclk_i,        // bus clock
    input wire logic rst_i,         // sync reset, active high
    input wire logic run_i,         // count only while high
    input wire logic [2:0] pre_i,   // prescale select
    input wire logic [2:0] div_i,   // rate divider select
    output logic tick_o             // one pulse per bit-rate edge period
);
    import spb_pkg::*;

    logic [2:0] pre_r, pre_nxt;
    logic [7:0] div_r, div_nxt;
    logic pre_tick;
    logic [7:0] div_last;
    logic tick_r, tick_nxt;

    // ******************************************************************
    // dividers
    // ******************************************************************
    // prescaler wraps at field value, so divisor is value plus one
    assign pre_tick = run_i && (pre_r >= pre_i);
    // divider wraps at 2^(field+1) - 1; shift amount is 4 bits so 7 gives 256
    assign div_last = 8'(({8'h00, 1'b1} << ({1'b0, div_i} + 4'h1))
        - 9'h001);

    // next counter values
    always_comb begin
        pre_nxt = pre_r;
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (!run_i) begin
            pre_nxt = 3'h0;
            div_nxt = 8'h00;
        end else if (pre_tick) begin
            pre_nxt = 3'h0;
            if (div_r >= div_last) begin
                div_nxt = 8'h00;
                tick_nxt = 1'b1;
            end else begin
                div_nxt = div_r + 8'h01;
            end
        end else begin
            pre_nxt = pre_r + 3'h1;
        end
    end

    // registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pre_r <= 3'h0;
            div_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule : spb_rate_gen

// file: spb_top.sv
// spi feature control and bit-rate generator with avalon register slave
// Contract
// - feature control bits 7,6,5,2 hold nothing and read zero
// - slave mode ignores mode-fault enable; select pin is low-true input
// - master with mode-fault off releases select pin to port i/o
// - master with mode-fault on uses pin as fault input or select output
// - select output enable: 0 fault input, 1 driven select output
// - single-wire mode: output enable bit 0 input, 1 drives pin
// - output enable bit ignored with separate data pins
// - single-wire: slave uses miso pin, master uses mosi pin
// - pin control 0 gives separate input and output data pins
// - single-wire master releases miso pin to port i/o
// - stop-in-wait 1 halts interface clocks during wait
// - bit-rate register readable and writable at any time
// - prescaler divides bus clock by field plus one
// - rate divider divides by two to 256 in powers of two
// - prescaler feeds divider; output is bit clock, master only
`timescale 1ns/10ps
module spb_top (
    input wire logic mclk_i,               // 25 mhz bus clock
    input wire logic rst_i,                // sync reset, active high
    // avalon-mm slave
    input wire logic [1:0] avs_address_i,  // word address
    input wire logic avs_read_i,           // read strobe
    input wire logic avs_write_i,          // write strobe
    input wire logic [3:0] avs_byteenable_i, // byte enables
    input wire logic [31:0] avs_writedata_i, // write data
    output logic [31:0] avs_readdata_o,    // read data
    output logic avs_waitrequest_o,        // stall
    // system
    input wire logic wait_mode_i,          // cpu in wait mode (same clock)
    input wire logic xfer_active_i,        // shifter busy (same clock)
    // pins
    input wire logic ss_pin_i,             // slave-select pin level
    input wire logic mosi_pin_i,           // mosi pin level
    input wire logic miso_pin_i,           // miso pin level
    input wire logic tx_bit_i,             // serial bit from shifter
    output logic ss_out_o,                 // select pin drive level
    output logic ss_oe_n_o,                // select drive enable, low drives
    output logic mosi_out_o,               // mosi drive level
    output logic mosi_oe_n_o,              // mosi drive enable, low drives
    output logic miso_out_o,               // miso drive level
    output logic miso_oe_n_o,              // miso drive enable, low drives
    // to shifter and port logic
    output logic rx_bit_o,                 // serial data in to shifter
    output logic ss_in_n_o,                // synced select input, low true
    output logic mode_fault_o,             // select low while fault input
    output spb_pkg::spb_route_t route_o,   // pin routing decisions
    output logic clk_run_o,                // interface clocks enabled
    output logic bit_tick_o                // master bit-rate enable pulse
);
    import spb_pkg::*;

    // ******************************************************************
    // registers and bus slave
    // ******************************************************************
    logic [7:0] fc_r, fc_nxt;
    logic [7:0] br_r, br_nxt;
    logic [7:0] md_r, md_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic ack_r, ack_nxt;
    logic [7:0] rd_byte;
    logic master, modf_en, select_output_enable, single, bidir_oe;

    // single wait state on every access; response one cycle later
    always_comb begin
        fc_nxt = fc_r;
        br_nxt = br_r;
        md_nxt = md_r;
        rd_nxt = rd_r;
        ack_nxt = 1'b0;
        unique case (avs_address_i)
            SPB_ADDR_FEATURE: rd_byte = fc_r & SPB_FC_MASK;
            SPB_ADDR_RATE: rd_byte = br_r & SPB_BR_MASK;
            SPB_ADDR_MODE: rd_byte = md_r & SPB_MD_MASK;
            default: rd_byte = 8'h00;                             // unmapped
        endcase
        if ((avs_read_i || avs_write_i) && !ack_r) begin
            ack_nxt = 1'b1;
            rd_nxt = {24'h0, rd_byte};
            if (avs_write_i && avs_byteenable_i[0]) begin
                unique case (avs_address_i)
                    SPB_ADDR_FEATURE: fc_nxt = avs_writedata_i[7:0]
                        & SPB_FC_MASK;
                    // accepted regardless of transfer state
                    SPB_ADDR_RATE: br_nxt = avs_writedata_i[7:0]
                        & SPB_BR_MASK;
                    SPB_ADDR_MODE: md_nxt = avs_writedata_i[7:0]
                        & SPB_MD_MASK;
                    default: ;
                endcase
            end
        end
    end

    // register state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fc_r <= SPB_FC_RESET;
            br_r <= SPB_BR_RESET;
            md_r <= SPB_MD_RESET;
            rd_r <= 32'h0;
            ack_r <= 1'b0;
        end else begin
            fc_r <= fc_nxt;
            br_r <= br_nxt;
            md_r <= md_nxt;
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign avs_readdata_o = rd_r;

    assign master = md_r[SPB_MD_MASTER];
    assign select_output_enable = md_r[SPB_MD_SELECT_OUTPUT_ENABLE];
    assign modf_en = fc_r[SPB_FC_MODF_EN];
    assign single = fc_r[SPB_FC_SINGLE];
    assign bidir_oe = fc_r[SPB_FC_BIDIR_OE];

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic [2:0] sync1_r, sync2_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync1_r <= {ss_pin_i, mosi_pin_i, miso_pin_i};
            sync2_r <= sync1_r;
        end
    end

    // ******************************************************************
    // pin routing
    // ******************************************************************
    spb_route_t rt;
    logic clk_run;

    always_comb begin
        rt = '0;
        if (!master) begin
            rt.ss_role = SPB_SS_SLAVE_IN;
        end else if (!modf_en) begin
            rt.ss_role = SPB_SS_GPIO;
        end else if (select_output_enable) begin
            rt.ss_role = SPB_SS_DRIVE_OUT;
        end else begin
            rt.ss_role = SPB_SS_FAULT_IN;
        end
        rt.shared_on_mosi = single && master;
        rt.shared_on_miso = single && !master;
        rt.miso_gpio = single && master;
        rt.shared_drive = single && bidir_oe;
    end

    // stop-in-wait halts interface clocks while the cpu waits
    assign clk_run = !(fc_r[SPB_FC_STOP_WAIT] && wait_mode_i);

    // data pin drives and receive selection
    always_comb begin
        mosi_oe_n_o = 1'b1;
        miso_oe_n_o = 1'b1;
        rx_bit_o = 1'b0;
        if (single) begin
            // shared pin drives only on bidir enable
            if (master) begin
                mosi_oe_n_o = !bidir_oe;
                rx_bit_o = sync2_r[1];
            end else begin
                miso_oe_n_o = !bidir_oe;
                rx_bit_o = sync2_r[0];
            end
        end else if (master) begin
            mosi_oe_n_o = 1'b0;
            rx_bit_o = sync2_r[0];
        end else begin
            miso_oe_n_o = !(!sync2_r[2]);
            rx_bit_o = sync2_r[1];
        end
    end

    assign mosi_out_o = tx_bit_i;
    assign miso_out_o = tx_bit_i;
    // automatic select: low while a transfer runs
    assign ss_oe_n_o = (rt.ss_role != SPB_SS_DRIVE_OUT);
    assign ss_out_o = !xfer_active_i;
    assign ss_in_n_o = (rt.ss_role == SPB_SS_SLAVE_IN) ? sync2_r[2]
        : 1'b1;
    assign mode_fault_o = (rt.ss_role == SPB_SS_FAULT_IN)
        && !sync2_r[2];
    assign route_o = rt;
    assign clk_run_o = clk_run;

    // ******************************************************************
    // bit-rate generator, master only
    // ******************************************************************
    spb_rate_gen u_rate (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .run_i(clk_run && master),
        .pre_i(br_r[SPB_BR_PRE_LSB +: 3]),
        .div_i(br_r[SPB_BR_DIV_LSB +: 3]),
        .tick_o(bit_tick_o)
    );
endmodule : spb_top

// file: spb_top_properties.sv
// checker: port-level properties of the spi pin and bit-rate block
`timescale 1ns/10ps
module spb_props (
    input wire logic mclk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [1:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_readdata_o, // read data
    input wire logic avs_waitrequest_o, // stall
    input wire logic wait_mode_i, // wait mode
    input wire logic xfer_active_i, // busy
    input wire logic ss_out_o, // select level
    input wire logic ss_oe_n_o, // select enable
    input wire logic mosi_oe_n_o, // mosi enable
    input wire logic miso_oe_n_o, // miso enable
    input wire logic ss_in_n_o, // select in
    input wire logic mode_fault_o, // fault
    input wire spb_pkg::spb_route_t route_o, // routing
    input wire logic clk_run_o, // clocks on
    input wire logic bit_tick_o // tick
);
    import spb_pkg::*;
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_fc_zero;
        avs_read_i && !avs_waitrequest_o && avs_address_i == SPB_ADDR_FEATURE
        |-> (avs_readdata_o & 32'hffffffe4) == 32'h0;
    endproperty
    a_fc_zero: assert property (p_fc_zero) else $error("fc spare bits");
    property p_wait;
        $rose(avs_read_i) || $rose(avs_write_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer");
    property p_slv; route_o.ss_role != SPB_SS_SLAVE_IN |-> ss_in_n_o; endproperty
    a_slv: assert property (p_slv) else $error("select in");
    property p_gpio;
        route_o.ss_role == SPB_SS_GPIO |-> ss_oe_n_o && !mode_fault_o;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin not free");
    property p_flt;
        mode_fault_o |-> route_o.ss_role == SPB_SS_FAULT_IN && ss_oe_n_o;
    endproperty
    a_flt: assert property (p_flt) else $error("fault role");
    property p_drv;
        route_o.ss_role == SPB_SS_DRIVE_OUT
        |-> !ss_oe_n_o && ss_out_o == !xfer_active_i;
    endproperty
    a_drv: assert property (p_drv) else $error("select drive");
    property p_shr;
        route_o.shared_on_mosi |-> mosi_oe_n_o == !route_o.shared_drive;
    endproperty
    a_shr: assert property (p_shr) else $error("shared pin");
    property p_rel; route_o.miso_gpio |-> miso_oe_n_o; endproperty
    a_rel: assert property (p_rel) else $error("miso held");
    property p_run; !wait_mode_i |-> clk_run_o; endproperty
    a_run: assert property (p_run) else $error("clock off");
    property p_halt; !clk_run_o [*3] |-> !bit_tick_o; endproperty
    a_halt: assert property (p_halt) else $error("tick halted");
    property p_mst;
        route_o.ss_role == SPB_SS_SLAVE_IN [*3] |-> !bit_tick_o;
    endproperty
    a_mst: assert property (p_mst) else $error("slave tick");
    c_flt: cover property (mode_fault_o);
    c_shr: cover property (route_o.shared_on_mosi && !mosi_oe_n_o);
    c_tick: cover property (bit_tick_o ##2 bit_tick_o);
endmodule : spb_props
bind spb_top spb_props u_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .wait_mode_i(wait_mode_i), .xfer_active_i(xfer_active_i),
    .ss_out_o(ss_out_o), .ss_oe_n_o(ss_oe_n_o), .mosi_oe_n_o(mosi_oe_n_o),
    .miso_oe_n_o(miso_oe_n_o), .ss_in_n_o(ss_in_n_o),
    .mode_fault_o(mode_fault_o), .route_o(route_o), .clk_run_o(clk_run_o),
    .bit_tick_o(bit_tick_o)
);

// file: spb_peer.sv
// partner: far-side spi device sharing the select and data wires
`timescale 1ns/10ps
module spb_peer (
    input wire logic ss_out_i, // design select level
    input wire logic ss_oe_n_i, // design select enable
    input wire logic mosi_out_i, // design mosi level
    input wire logic mosi_oe_n_i, // design mosi enable
    input wire logic miso_out_i, // design miso level
    input wire logic miso_oe_n_i, // design miso enable
    input wire logic ss_lvl_i, // peer select level
    input wire logic dat_lvl_i, // peer data level
    output logic ss_pin_o, // select wire
    output logic mosi_pin_o, // mosi wire
    output logic miso_pin_o // miso wire
);
    // ****************************************************************
    // wire resolution: design level while it drives, else the peer's
    // ****************************************************************
    assign ss_pin_o = ss_oe_n_i ? ss_lvl_i : ss_out_i;
    assign mosi_pin_o = mosi_oe_n_i ? dat_lvl_i : mosi_out_i;
    assign miso_pin_o = miso_oe_n_i ? dat_lvl_i : miso_out_i;
endmodule : spb_peer

// file: spb_top_tb.sv
// testbench: registers, pin roles and bit rate of spb_top
`timescale 1ns/10ps
module spb_top_tb;
    import spb_pkg::*;
    // ****************************************************************
    // signals, design and peer
    // ****************************************************************
    localparam logic [7:0] RATES [4] = '{8'h00, 8'h70, 8'h23, 8'h77};
    logic mclk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0;
    logic avs_write_i = 1'b0, wait_mode_i = 1'b0, xfer_active_i = 1'b0;
    logic ss_lvl = 1'b1;
    logic [1:0] avs_address_i = 2'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdata;
    logic avs_waitrequest_o, ss_pin, mosi_pin, miso_pin, ss_out_o, ss_oe_n_o;
    logic mosi_out_o, mosi_oe_n_o, miso_out_o, miso_oe_n_o, rx_bit_o;
    logic ss_in_n_o, mode_fault_o, clk_run_o, bit_tick_o;
    spb_route_t route_o;
    int miscompares = 0;
    int cmp_count = 0;
    always #20 mclk_i = ~mclk_i;
    spb_top uut (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_byteenable_i(4'h1), .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .wait_mode_i, .xfer_active_i, .ss_pin_i(ss_pin),
        .mosi_pin_i(mosi_pin), .miso_pin_i(miso_pin), .tx_bit_i(1'b0),
        .ss_out_o, .ss_oe_n_o, .mosi_out_o, .mosi_oe_n_o, .miso_out_o,
        .miso_oe_n_o, .rx_bit_o, .ss_in_n_o, .mode_fault_o, .route_o,
        .clk_run_o, .bit_tick_o);
    spb_peer peer (.ss_out_i(ss_out_o), .ss_oe_n_i(ss_oe_n_o),
        .mosi_out_i(mosi_out_o), .mosi_oe_n_i(mosi_oe_n_o),
        .miso_out_i(miso_out_o), .miso_oe_n_i(miso_oe_n_o), .ss_lvl_i(ss_lvl),
        .dat_lvl_i(1'b1), .ss_pin_o(ss_pin), .mosi_pin_o(mosi_pin),
        .miso_pin_o(miso_pin));
    // verdict and end of run
    task results;
        $display("miscompares %0d checks %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tmo(input int n);
        if (n >= 3000) begin
            miscompares++;
            results();
        end
    endtask : tmo
    // one avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 3000);
        tmo(n);
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    // ticks seen over 40 cycles once settled
    task cnt(output int n);
        n = 0;
        repeat (4) @(negedge mclk_i);
        repeat (40) begin
            @(negedge mclk_i);
            n += (bit_tick_o === 1'b1);
        end
    endtask : cnt
    task t_regs;
        bus(1'b0, SPB_ADDR_FEATURE, 8'h00);
        chk("fc reset", rdata, 32'h0);
        bus(1'b0, SPB_ADDR_RATE, 8'h00);
        chk("br reset", rdata, 32'h0);
        bus(1'b1, SPB_ADDR_FEATURE, 8'hff);
        bus(1'b0, SPB_ADDR_FEATURE, 8'h00);
        chk("fc mask", rdata, 32'h1b);
        xfer_active_i <= 1'b1;
        bus(1'b1, SPB_ADDR_RATE, 8'hff);
        bus(1'b0, SPB_ADDR_RATE, 8'h00);
        chk("br busy", rdata, 32'h77);
        bus(1'b0, 2'h3, 8'h00);
        chk("unmapped", rdata, 32'h0);
        bus(1'b1, SPB_ADDR_MODE, 8'hff);
        bus(1'b0, SPB_ADDR_MODE, 8'h00);
        chk("md mask", rdata, 32'h3);
        xfer_active_i <= 1'b0;
        $display("test regs done");
    endtask : t_regs
    // every mode, fault, output-enable, single-wire and direction mix
    task t_route;
        logic m, so, mf, sw, bo;
        spb_ss_role_t role;
        ss_lvl <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            {bo, sw, mf, so, m} = i[4:0];
            bus(1'b1, SPB_ADDR_MODE, {6'h0, so, m});
            bus(1'b1, SPB_ADDR_FEATURE, {3'h0, mf, bo, 2'h0, sw});
            role = !m ? SPB_SS_SLAVE_IN : !mf ? SPB_SS_GPIO
                : so ? SPB_SS_DRIVE_OUT : SPB_SS_FAULT_IN;
            repeat (3) @(negedge mclk_i);
            chk("ss role", route_o.ss_role, role);
            chk("fault", mode_fault_o, role == SPB_SS_FAULT_IN);
            chk("ss in", ss_in_n_o, m);
            chk("mosi oe", mosi_oe_n_o,
                sw ? !(m && bo) : !m);
            chk("miso oe", miso_oe_n_o, m || (sw && !bo));
            chk("ss oe", ss_oe_n_o, role != SPB_SS_DRIVE_OUT);
            chk("rx bit", rx_bit_o, !(sw && bo));
            chk("shared", {route_o.shared_on_mosi, route_o.shared_on_miso,
                route_o.miso_gpio, route_o.shared_drive},
                {sw && m, sw && !m, sw && m, sw && bo});
            chk("tx out", {mosi_out_o, miso_out_o}, 2'h0);
        end
        $display("test route done");
    endtask : t_route
    task t_rate;
        int n;
        bus(1'b1, SPB_ADDR_MODE, 8'h01);
        bus(1'b1, SPB_ADDR_FEATURE, 8'h00);
        foreach (RATES[k]) begin
            bus(1'b1, SPB_ADDR_RATE, RATES[k]);
            repeat (3) begin
                n = 0;
                do begin
                    @(negedge mclk_i);
                    n++;
                end while (bit_tick_o !== 1'b1 && n < 3000);
                tmo(n);
            end
            chk("period", n, (RATES[k][6:4] + 32'h1)
                << (RATES[k][2:0] + 32'h1));
        end
        $display("test rate done");
    endtask : t_rate
    task t_halt;
        int n;
        bus(1'b1, SPB_ADDR_RATE, 8'h00);
        bus(1'b1, SPB_ADDR_FEATURE, 8'h02);
        wait_mode_i <= 1'b1;
        cnt(n);
        chk("halt ticks", n, 32'h0);
        chk("halt run", clk_run_o, 32'h0);
        bus(1'b1, SPB_ADDR_FEATURE, 8'h00);
        cnt(n);
        chk("wait ticks", n, 32'h14);
        bus(1'b1, SPB_ADDR_MODE, 8'h00);
        cnt(n);
        chk("slave ticks", n, 32'h0);
        @(posedge mclk_i);
        wait_mode_i <= 1'b0;
        $display("test halt done");
    endtask : t_halt
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs();
        t_route();
        t_rate();
        t_halt();
        results();
    end
endmodule : spb_top_tb
